// *** i2c_protocol_trigger.sv ***
`timescale 1ns/1ps
module i2c_protocol_trigger
  import i2c_trig_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  input  wire logic [MODE_W-1:0]   trig_mode,
  input  wire logic                long_addr_len,
  input  wire logic                dir_read,
  input  wire logic                ignore_addr,
  input  wire logic [ADDR_W-1:0]   target_addr,
  input  wire logic [OFFSET_W-1:0] byte_offset,
  input  wire logic [LEN_W-1:0]    pattern_byte_len,
  input  wire logic [PAT_W-1:0]    pat_value,
  input  wire logic [PAT_W-1:0]    pat_care,
  output logic                     trig_pulse,
  output logic                     frame_active,
  output logic [LEN_W-1:0]         eff_pattern_len
);

  typedef struct packed {
    logic [LINE_W-1:0]    lines_q;
    logic                 in_frame;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [7:0]           shreg;
    phase_type            phase;
    logic [1:0]           long_hi;
    logic                 addr_ok;
    logic                 dir_ok;
    logic                 rs_long;
    logic [OFFSET_W-1:0]  skip_cnt;
    logic [LEN_W-1:0]     pat_idx;
    logic                 pat_dead;
    logic [LEN_W-1:0]     len;
    logic                 trig;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic [LINE_W-1:0]    lines;
  logic                 scl;
  logic                 sda;
  logic                 start_evt;
  logic                 stop_evt;
  logic                 scl_rise;
  logic                 byte_done;
  logic                 ack_slot;
  logic [7:0]           rx_byte;
  logic [PAT_BYTES-1:0] byte_has_care;
  logic [LEN_W-1:0]     len_calc;
  logic                 qual;
  logic                 addr_only;

  // Lines are sampled through a three-stage synchroniser.
  line_sync u_sync (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .lines_in  ({scl_in, sda_in}),
    .lines_out (lines)
  );

  // Picks pattern byte idx; byte 0 is the most significant byte.
  function automatic logic [7:0] pat_slice(input logic [PAT_W-1:0] v,
                                           input logic [LEN_W-1:0] idx);
    case (idx)
      2'h0:    pat_slice = v[23:16];
      2'h1:    pat_slice = v[15:8];
      default: pat_slice = v[7:0];
    endcase
  endfunction : pat_slice

  // Flags each pattern byte that holds at least one defined bit.
  for (genvar i = 0; i < PAT_BYTES; i++) begin : g_care
    assign byte_has_care[i] = |pat_slice(pat_care, LEN_W'(i));
  end

  // A pattern without any defined bit reduces the match to the address alone.
  assign addr_only = ~|byte_has_care;

  // Effective length grows to cover every byte with defined bits.
  always_comb begin
    if (byte_has_care[2]) begin
      len_calc = LEN_MAX;
    end else if (byte_has_care[1]) begin
      len_calc = (pattern_byte_len > 2'h2) ? LEN_MAX : 2'h2;
    end else if (byte_has_care[0]) begin
      len_calc = (pattern_byte_len == 2'h0) ? 2'h1 : pattern_byte_len;
    end else begin
      // No defined bits: the setting stands; matching is then address only.
      len_calc = pattern_byte_len;
    end
  end

  // Bus conditions from the synchronised lines.
  assign scl       = lines[SCL_BIT];
  assign sda       = lines[SDA_BIT];
  assign start_evt = scl & st_r.lines_q[SCL_BIT] & st_r.lines_q[SDA_BIT] & ~sda;
  assign stop_evt  = scl & st_r.lines_q[SCL_BIT] & ~st_r.lines_q[SDA_BIT] & sda;
  assign scl_rise  = scl & ~st_r.lines_q[SCL_BIT];
  assign byte_done = scl_rise & (st_r.bit_cnt == LAST_DATA_BIT);
  assign ack_slot  = scl_rise & (st_r.bit_cnt == ACK_SLOT);
  assign rx_byte   = {st_r.shreg[6:0], sda};
  // Address qualification, skipped entirely when the address is ignored.
  assign qual      = ignore_addr | (st_r.addr_ok & st_r.dir_ok);

  // Frame tracking, byte assembly, address decode and pattern matching.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.lines_q = lines;
    st_nxt.trig    = 1'b0;
    st_nxt.len     = len_calc;
    if (start_evt || stop_evt) begin
      // A new condition restarts byte counting and matching.
      st_nxt.bit_cnt  = '0;
      st_nxt.shreg    = '0;
      st_nxt.addr_ok  = 1'b0;
      st_nxt.dir_ok   = 1'b0;
      st_nxt.skip_cnt = '0;
      st_nxt.pat_idx  = '0;
      st_nxt.pat_dead = 1'b0;
      st_nxt.in_frame = start_evt;
      st_nxt.phase    = start_evt ? PH_ADDR1 : PH_IDLE;
      // Ten-bit address match survives only a repeated start.
      st_nxt.rs_long  = start_evt & st_r.in_frame & st_r.rs_long;
      // At most one mode fires; the other mode codes give no pulse here.
      case (trig_mode)
        MODE_START:   st_nxt.trig = start_evt;
        MODE_STOP:    st_nxt.trig = stop_evt;
        MODE_RESTART: st_nxt.trig = start_evt & st_r.in_frame;
        default:      st_nxt.trig = 1'b0;
      endcase
    end else if (ack_slot) begin
      st_nxt.bit_cnt = '0;
      // A high data line in the ninth slot is a missing acknowledge.
      st_nxt.trig = (trig_mode == MODE_NO_ACK) & sda & (st_r.phase != PH_IDLE);
    end else if (scl_rise && st_r.phase != PH_IDLE) begin
      st_nxt.bit_cnt = st_r.bit_cnt + BIT_CNT_W'(1);
      st_nxt.shreg   = rx_byte;
      if (byte_done) begin
        case (st_r.phase)
          PH_ADDR1: begin
            // Direction from bit eight; one means read.
            st_nxt.dir_ok = (rx_byte[0] == dir_read);
            st_nxt.phase  = PH_DATA;
            st_nxt.rs_long = 1'b0;
            if (!long_addr_len) begin
              st_nxt.addr_ok = (rx_byte[7:1] == target_addr[6:0]);
            end else if (rx_byte[7:3] != LONG_PREFIX) begin
              st_nxt.addr_ok = 1'b0;
            end else if (st_r.rs_long && rx_byte[2:1] == st_r.long_hi
                         && rx_byte[0] == DIR_READ) begin
              st_nxt.addr_ok = 1'b1;
            end else begin
              st_nxt.long_hi = rx_byte[2:1];
              st_nxt.phase   = PH_ADDR2;
            end
            st_nxt.pat_dead = addr_only && (st_nxt.phase == PH_DATA);
          end
          PH_ADDR2: begin
            // Low eight address bits complete the ten-bit compare.
            st_nxt.addr_ok  = ({st_r.long_hi, rx_byte} == target_addr);
            st_nxt.rs_long  = ({st_r.long_hi, rx_byte} == target_addr);
            st_nxt.phase    = PH_DATA;
            st_nxt.pat_dead = addr_only;
          end
          PH_DATA: begin
            if (st_r.pat_dead) begin
              st_nxt.pat_dead = 1'b1;
            end else if (st_r.skip_cnt != byte_offset) begin
              st_nxt.skip_cnt = st_r.skip_cnt + OFFSET_W'(1);
            end else if (((rx_byte ^ pat_slice(pat_value, st_r.pat_idx))
                          & pat_slice(pat_care, st_r.pat_idx)) == 8'h00) begin
              if (st_r.pat_idx + LEN_W'(1) == st_r.len) begin
                st_nxt.trig     = (trig_mode == MODE_ADDR_DATA) & qual;
                st_nxt.pat_dead = 1'b1;
              end else begin
                st_nxt.pat_idx = st_r.pat_idx + LEN_W'(1);
              end
            end else begin
              st_nxt.pat_dead = 1'b1;
            end
          end
          default: st_nxt.phase = PH_IDLE;
        endcase
        // All-don't-care pattern: fire on address and direction alone, never while the address is ignored.
        if (st_r.phase != PH_DATA && st_nxt.phase == PH_DATA && addr_only) begin
          st_nxt.trig = (trig_mode == MODE_ADDR_DATA) & st_nxt.addr_ok & st_nxt.dir_ok
                        & ~ignore_addr;
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r         <= '0;
      st_r.lines_q <= LINES_IDLE;
      st_r.phase   <= PH_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trig_pulse      = st_r.trig;
  assign frame_active    = st_r.in_frame;
  assign eff_pattern_len = st_r.len;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_ack_high;
    ack_slot && sda && trig_mode == MODE_NO_ACK && st_r.phase != PH_IDLE;
  endsequence

  sequence s_start_in_mode;
    start_evt && trig_mode == MODE_START;
  endsequence

  property p_start;
    s_start_in_mode |=> trig_pulse;
  endproperty
  a_start: assert property (p_start) else $error("start not triggered");

  property p_stop;
    stop_evt && trig_mode == MODE_STOP |=> trig_pulse ##1 !trig_pulse;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not triggered");

  property p_restart;
    trig_pulse && $past(trig_mode) == MODE_RESTART |-> $past(start_evt) && $past(st_r.in_frame);
  endproperty
  a_restart: assert property (p_restart) else $error("restart without open frame");

  property p_noack;
    s_ack_high |=> trig_pulse && st_r.bit_cnt == 4'h0;
  endproperty
  a_noack: assert property (p_noack) else $error("missing ack not triggered");

  property p_single;
    trig_pulse |=> !trig_pulse;
  endproperty
  a_single: assert property (p_single) else $error("trigger longer than a cycle");

  property p_cond_reset;
    start_evt || stop_evt |=> st_r.bit_cnt == 4'h0 && st_r.pat_idx == 2'h0 && !st_r.addr_ok;
  endproperty
  a_cond_reset: assert property (p_cond_reset) else $error("frame state not reset");

  property p_len_grow;
    ##1 eff_pattern_len >= $past(pattern_byte_len) || $past(pattern_byte_len) > LEN_MAX;
  endproperty
  a_len_grow: assert property (p_len_grow) else $error("length below setting");

  property p_long_prefix;
    byte_done && st_r.phase == PH_ADDR1 && long_addr_len && !st_r.rs_long
      && rx_byte[7:3] == LONG_PREFIX |=> st_r.phase == PH_ADDR2;
  endproperty
  a_long_prefix: assert property (p_long_prefix) else $error("long prefix not decoded");

  property p_skip;
    st_r.skip_cnt <= byte_offset || $changed(byte_offset);
  endproperty
  a_skip: assert property (p_skip) else $error("skip count overran offset");

endmodule : i2c_protocol_trigger

// *** i2c_trig_pkg.sv ***
package i2c_trig_pkg;

  // Synchronised line vector: clock line above data line.
  localparam int          LINE_W     = 2;
  localparam int          SCL_BIT    = 1;
  localparam int          SDA_BIT    = 0;
  localparam logic [1:0]  LINES_IDLE = 2'h3;

  // Trigger mode codes.
  localparam int          MODE_W         = 3;
  localparam logic [2:0]  MODE_START     = 3'h0;
  localparam logic [2:0]  MODE_STOP      = 3'h1;
  localparam logic [2:0]  MODE_RESTART   = 3'h2;
  localparam logic [2:0]  MODE_NO_ACK    = 3'h3;
  localparam logic [2:0]  MODE_ADDR_DATA = 3'h4;

  // Address and pattern layout.
  localparam int          ADDR_W      = 10;
  localparam int          OFFSET_W    = 12;
  localparam int          PAT_BYTES   = 3;
  localparam int          PAT_W       = 24;
  localparam int          LEN_W       = 2;
  localparam logic [1:0]  LEN_MAX     = 2'h3;
  localparam logic [4:0]  LONG_PREFIX = 5'h1E;
  localparam logic        DIR_READ    = 1'b1;

  // Bit slot counter: eight data bits then the acknowledge slot.
  localparam int          BIT_CNT_W     = 4;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR1, PH_ADDR2, PH_DATA} phase_type;

endpackage : i2c_trig_pkg

// *** line_sync.sv ***
`timescale 1ns/1ps
module line_sync
  import i2c_trig_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [LINE_W-1:0] lines_in,
  output logic      [LINE_W-1:0] lines_out
);

  typedef struct packed {
    logic [LINE_W-1:0] st1;
    logic [LINE_W-1:0] st2;
    logic [LINE_W-1:0] st3;
    logic [LINE_W-1:0] lvl;
  } sync_type;

  sync_type sync_r;
  sync_type sync_nxt;

  // Three stages; the level rises once stages two and three are both high and falls as soon as either is low.
  always_comb begin
    sync_nxt     = sync_r;
    sync_nxt.st1 = lines_in;
    sync_nxt.st2 = sync_r.st1;
    sync_nxt.st3 = sync_r.st2;
    sync_nxt.lvl = (sync_r.lvl & ~(sync_r.st2 ^ sync_r.st3))
                 | (sync_r.st3 & ~(sync_r.st2 ^ sync_r.st3));
  end

  // Idle bus lines are high, so reset to high.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_r <= {LINES_IDLE, LINES_IDLE, LINES_IDLE, LINES_IDLE};
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign lines_out = sync_r.lvl;

endmodule : line_sync

// *** i2c_bus_model.sv ***
`timescale 1ns/1ps
module i2c_bus_model (
  output logic scl_o,
  output logic sda_o
);
  // A quarter of the 320 ns link period; SCL stands high between frames.
  localparam time QTR = 80;

  // The bus idles with both lines pulled high.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Start or repeated start: SDA falls while SCL is high.
  task automatic send_start();
    scl_o = 1'b0;
    #QTR sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_o = 1'b0;
    #(2*QTR);
  endtask : send_start

  // Stop: SDA rises while SCL is high, then both lines rest high.
  task automatic send_stop();
    scl_o = 1'b0;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_o = 1'b1;
    #(2*QTR);
  endtask : send_stop

  // Eight bits MSB first, then the acknowledge slot; a released SDA reads high.
  task automatic send_byte(input logic [7:0] val, input logic ack);
    for (int i = 7; i >= -1; i--) begin
      scl_o = 1'b0;
      #QTR sda_o = (i < 0) ? ~ack : val[i];
      #QTR scl_o = 1'b1;
      #(2*QTR);
    end
  endtask : send_byte
endmodule : i2c_bus_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import i2c_trig_pkg::*;
  localparam time        DLY = 1;
  localparam logic [9:0] BS  = 10'h200;  // Start marker; 10'h1xx is a byte left unacknowledged.
  localparam logic [9:0] BP  = 10'h300;  // Stop marker.

  logic                sys_clk;
  logic                srst;
  logic                scl_line;
  logic                sda_line;
  logic [MODE_W-1:0]   trig_mode;
  logic                long_addr_len;
  logic                dir_read;
  logic                ignore_addr;
  logic [ADDR_W-1:0]   target_addr;
  logic [OFFSET_W-1:0] byte_offset;
  logic [LEN_W-1:0]    pattern_byte_len;
  logic [PAT_W-1:0]    pat_value;
  logic [PAT_W-1:0]    pat_care;
  logic                trig_pulse;
  logic                frame_active;
  logic [LEN_W-1:0]    eff_pattern_len;
  logic [31:0]         pulse_cnt = 0;
  logic [31:0]         wide_cnt  = 0;
  logic [31:0]         act_cnt   = 0;
  logic                last_pulse = 1'b0;
  logic [31:0]         cyc = 0;
  logic [9:0]          frm[$];
  int                  err_count = 0;
  int                  n_tests   = 0;

  i2c_bus_model i2c_bus_model_inst (.scl_o(scl_line), .sda_o(sda_line));

  i2c_protocol_trigger i2c_protocol_trigger_inst (
    .sys_clk(sys_clk), .srst(srst), .scl_in(scl_line), .sda_in(sda_line),
    .trig_mode(trig_mode), .long_addr_len(long_addr_len), .dir_read(dir_read),
    .ignore_addr(ignore_addr), .target_addr(target_addr), .byte_offset(byte_offset),
    .pattern_byte_len(pattern_byte_len), .pat_value(pat_value), .pat_care(pat_care),
    .trig_pulse(trig_pulse), .frame_active(frame_active), .eff_pattern_len(eff_pattern_len)
  );

  // The 25 MHz sampling clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Counts trigger pulses, pulses longer than one cycle and cycles inside a frame.
  always @(posedge sys_clk) begin
    if (trig_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
    if (frame_active === 1'b1) act_cnt <= act_cnt + 1;
    if (trig_pulse === 1'b1 && last_pulse) wide_cnt <= wide_cnt + 1;
    last_pulse <= (trig_pulse === 1'b1);
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Configuration only changes between frames, just after a clock edge.
  task automatic set_cfg(input logic [2:0] m, input logic lg, input logic dr, input logic ig,
                         input logic [9:0] ta, input logic [11:0] off, input logic [1:0] ln,
                         input logic [23:0] val, input logic [23:0] care);
    @(posedge sys_clk);
    #DLY;
    {trig_mode, long_addr_len, dir_read, ignore_addr} = {m, lg, dr, ig};
    {target_addr, byte_offset, pattern_byte_len} = {ta, off, ln};
    {pat_value, pat_care} = {val, care};
  endtask : set_cfg

  // Plays the queued frame on the bus and compares the number of pulses it caused.
  task automatic run_frame(input logic [31:0] exp);
    logic [31:0] base;
    logic [31:0] act_base;
    base = pulse_cnt;
    act_base = act_cnt;
    foreach (frm[i]) begin
      if (frm[i] == BS) i2c_bus_model_inst.send_start();
      else if (frm[i] == BP) i2c_bus_model_inst.send_stop();
      else i2c_bus_model_inst.send_byte(frm[i][7:0], ~frm[i][8]);
    end
    repeat (20) @(posedge sys_clk);
    check(pulse_cnt - base, exp);
    check({31'h0, frame_active}, 32'h0);
    check({31'h0, act_cnt != act_base}, 32'h1);
  endtask : run_frame

  // Every mode code, including unused ones, against one frame with a restart and a nack.
  task automatic test_modes();
    logic [31:0] exp[8];
    exp = '{2, 1, 1, 1, 0, 0, 0, 0};
    frm = {BS, 10'h0A4, 10'h15A, BS, 10'h0A5, BP};
    for (int m = 0; m < 8; m++) begin
      set_cfg(m[2:0], 1'b0, 1'b0, 1'b0, 10'h07F, 12'h000, 2'h1, 24'h0, 24'hFF0000);
      run_frame(exp[m]);
    end
  endtask : test_modes

  // Seven-bit address, direction, exact compare, ignore option, offset and don't-care.
  task automatic test_addr7();
    frm = {BS, 10'h0A4, 10'h011, 10'h022, 10'h1C5, BP};
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h001, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(1);
    set_cfg(3'h4, 1'b0, 1'b1, 1'b0, 10'h052, 12'h001, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(0);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h053, 12'h001, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(0);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b1, 10'h053, 12'h001, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(1);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h000, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(0);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h001, 2'h2, 24'h22CD00, 24'hFFF700);
    run_frame(1);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'hFFF, 2'h2, 24'h22C500, 24'hFFFF00);
    run_frame(0);
  endtask : test_addr7

  // Ten-bit write and read addressing with an address-only pattern.
  task automatic test_addr10();
    frm = {BS, 10'h0F4, 10'h0A3, 10'h077, BP};
    set_cfg(3'h4, 1'b1, 1'b0, 1'b0, 10'h2A3, 12'h000, 2'h0, 24'h0, 24'h0);
    run_frame(1);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h2A3, 12'h000, 2'h0, 24'h0, 24'h0);
    run_frame(0);
    frm = {BS, 10'h0F4, 10'h0A3, BS, 10'h0F5, 10'h177, BP};
    set_cfg(3'h4, 1'b1, 1'b1, 1'b0, 10'h2A3, 12'h000, 2'h0, 24'h0, 24'h0);
    run_frame(1);
  endtask : test_addr10

  // A repeated start restarts the byte count of the pattern search.
  task automatic test_restart_clears();
    frm = {BS, 10'h0A4, 10'h011, BS, 10'h0A4, 10'h022, BP};
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h001, 2'h1, 24'h220000, 24'hFF0000);
    run_frame(0);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h000, 2'h1, 24'h220000, 24'hFF0000);
    run_frame(1);
  endtask : test_restart_clears

  // The effective length grows to cover every byte that holds defined bits.
  task automatic test_eff_len();
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h000, 2'h0, 24'h0, 24'h0000FF);
    repeat (3) @(posedge sys_clk);
    check(eff_pattern_len, 2'h3);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h000, 2'h0, 24'h0, 24'h800000);
    repeat (3) @(posedge sys_clk);
    check(eff_pattern_len, 2'h1);
    set_cfg(3'h4, 1'b0, 1'b0, 1'b0, 10'h052, 12'h000, 2'h2, 24'h0, 24'h0);
    repeat (3) @(posedge sys_clk);
    check(eff_pattern_len, 2'h2);
  endtask : test_eff_len

  // Reset, the scenarios, then the verdict.
  initial begin
    srst = 1'b1;
    {trig_mode, long_addr_len, dir_read, ignore_addr, target_addr} = '0;
    {byte_offset, pattern_byte_len, pat_value, pat_care} = '0;
    repeat (20) @(posedge sys_clk);
    #DLY srst = 1'b0;
    repeat (5) @(posedge sys_clk);
    test_modes();
    test_addr7();
    test_addr10();
    test_restart_clears();
    test_eff_len();
    check(wide_cnt, 32'h0);
    finish_test();
  end
endmodule : tb
